// ==== logic/qbp_pkg.sv ====
// shared constants and types of the parallel port block
// assumes a single clock domain; each tick of clk_in is one clock phase, or 32 ticks while slow-down is set
package qbp_pkg;
  // register byte offsets on the APB bus
  localparam logic [7:0] LATCH_BASE = 8'h00;
  localparam logic [7:0] PIN_BASE = 8'h20;
  localparam logic [7:0] ANA_MASK_OFS = 8'h40;
  localparam logic [7:0] SYS_CFG_OFS = 8'h44;
  localparam logic [7:0] CONV_CTRL0_OFS = 8'hd8;
  // port geometry
  localparam int NUM_PORTS = 6;
  localparam int NUM_PINS = 46;
  localparam logic [2:0] LAST_PORT = 3'h5;
  localparam logic [7:0] P5_MASK = 8'h3f;
  // reset values
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] ANA_MASK_RST = 8'hff;
  localparam logic [7:0] CONV_CTRL0_RST = 8'h00;
  localparam logic [2:0] SYS_CFG_RST = 3'h0;
  // field positions
  localparam int CLK_EN_BIT = 6;
  localparam logic [7:0] CONV_CTRL0_USED = 8'h40;
  localparam int REGISTER_MAP_SELECT_BIT = 0;
  localparam int LCD_EN_BIT = 1;
  localparam int SLOW_BIT = 2;
  // pin indices in the flat 46-bit pin vectors
  localparam int P1_BASE = 8;
  localparam int P2_BASE = 16;
  localparam int P3_BASE = 24;
  localparam int P4_BASE = 32;
  localparam int P5_BASE = 40;
  localparam int SYSTEM_CLOCK_PIN_PIN = P1_BASE + 6;
  localparam int TXD_PIN = P3_BASE + 1;
  localparam int COL31_PIN = P3_BASE + 4;
  localparam int COL30_PIN = P3_BASE + 5;
  localparam int WR_PIN = P3_BASE + 6;
  localparam int RD_PIN = P3_BASE + 7;
  // timing
  localparam logic [4:0] SLOW_DIV_M1 = 5'h1f;

  // machine-cycle states, each lasting two phases
  typedef enum logic [5:0] {
    ST_S1 = 6'b000001,
    ST_S2 = 6'b000010,
    ST_S3 = 6'b000100,
    ST_S4 = 6'b001000,
    ST_S5 = 6'b010000,
    ST_S6 = 6'b100000
  } qbp_state_t;

  // external memory bus request from the core
  typedef struct packed {
    logic active;
    logic wide;
    logic p0_drive;
    logic [7:0] addr_hi;
    logic [7:0] p0_data;
  } qbp_xmem_t;
endpackage : qbp_pkg

// ==== logic/qbp_sync2.sv ====
// two-stage synchroniser for the pad inputs
// assumes nothing of the input timing
`timescale 1ns/1ps
module qbp_sync2 #(
  parameter int W = 46
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // asynchronous level and its synchronised copy
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : qbp_sync2

// ==== logic/qbp_mcycle.sv ====
// machine-cycle sequencer and system clock level
// assumes clk_in is the phase clock; slow_in comes from the same domain
`timescale 1ns/1ps
module qbp_mcycle
  import qbp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // control
  input wire logic slow_in,
  // sequence state
  output qbp_state_t state_out,
  output logic phase2_out,
  output logic sysclk_out
);
  logic [4:0] pre_r;
  logic tick;
  qbp_state_t succ;
  qbp_state_t st_nxt;

  assign tick = !slow_in || (pre_r == SLOW_DIV_M1);
  assign st_nxt = phase2_out ? succ : state_out;

  always_comb begin
    case (state_out)
      ST_S1: succ = ST_S2;
      ST_S2: succ = ST_S3;
      ST_S3: succ = ST_S4;
      ST_S4: succ = ST_S5;
      ST_S5: succ = ST_S6;
      ST_S6: succ = ST_S1;
      default: succ = ST_S1;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_r <= 5'h00;
      state_out <= ST_S1;
      phase2_out <= 1'b0;
      sysclk_out <= 1'b0;
    end else begin
      pre_r <= tick ? 5'h00 : pre_r + 5'h01;
      if (tick) begin
        phase2_out <= !phase2_out;
        state_out <= st_nxt;
        sysclk_out <= (st_nxt == ST_S3);
      end
    end
  end
endmodule : qbp_mcycle

// ==== logic/qbp_ports.sv ====
// parallel port block: latches, pin drivers, clock output, APB registers
// assumes the core drives its strobes and bus requests on clk_in
//
// What this block does
// - clock-out enable bit 6 of converter control puts osc/12 on P1.6.
// - clock reaches the pin only while the P1.6 latch holds one.
// - clock high in state 3 both phases, low otherwise, duty 1:6.
// - during external moves the high pulse falls in last strobed state 3.
// - slow-down divides the system clock output by a further 32.
// - reserved converter control bits read undefined; software ignores them.
// - 46 lines: five 8-bit ports, one 6-bit; latch, driver, input each.
// - every port is read and written at its own register address.
// - latch is a D flip-flop: write strobe loads, read-latch returns it.
// - read-pin returns the actual pin level; instructions pick a path.
// - ports 1-5 quasi-bidirectional with pull-ups; port 0 open drain.
// - port 0 latch one turns both drivers off; pin floats.
// - port 0 pull-up only while driving ones in external cycles.
// - external cycles: port 0 carries low address multiplexed with data.
// - port 2 drives high address in wide accesses, else its latch.
// - port 1 digital after reset; mask bit zero makes pin analog.
// - analog mask reachable only while register map select is set.
// - port 1 alternates: analog, interrupts, capture, timer 2, clock out.
// - port 3 alternates: serial, interrupts, timer inputs, write/read.
// - LCD columns 16-29 on ports 4-5; 30 on P3.5, 31 on P3.4.
// - reset sets every port latch to one.
`timescale 1ns/1ps
module qbp_ports
  import qbp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // core side: external bus, strobes and alternate outputs
  input wire qbp_xmem_t xmem_in,
  input wire logic rd_strobe_n_in,
  input wire logic wr_strobe_n_in,
  input wire logic txd_in,
  input wire logic [15:0] lcd_col_in,
  // core side: alternate inputs and status
  output logic [NUM_PINS-1:0] pin_level_out,
  output logic [7:0] analog_sel_out,
  output qbp_state_t mstate_out,
  // pads
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_out,
  output logic [7:0] p0_pullup_en_out
);
  // register file
  logic [7:0] latch_r [NUM_PORTS];
  logic [7:0] ana_mask_r;
  logic [7:0] conv_ctrl_r;
  logic [2:0] sys_cfg_r;
  logic [NUM_PINS-1:0] pin_out_nxt;
  logic [NUM_PINS-1:0] pin_oe_nxt;
  logic [7:0] pullup_nxt;
  logic [31:0] rdata_nxt;
  logic err_nxt;

  // sequencer and synchronised pads
  qbp_state_t state;
  logic sysclk;
  logic [NUM_PINS-1:0] pin_sync;

  qbp_mcycle u_mcycle (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .slow_in(sys_cfg_r[SLOW_BIT]),
    .state_out(state),
    .phase2_out(),
    .sysclk_out(sysclk)
  );

  qbp_sync2 #(.W(NUM_PINS)) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // address decode helpers
  function automatic logic [2:0] port_sel(input logic [7:0] a);
    port_sel = a[4:2];
  endfunction : port_sel

  function automatic logic port_ok(input logic [7:0] a, input logic [7:0] base);
    port_ok = (a[7:5] == base[7:5]) && (a[1:0] == 2'b00) && (port_sel(a) <= LAST_PORT);
  endfunction : port_ok

  // APB phases: one wait state, so prdata and pready come from flops
  wire access = psel_in && penable_in;
  wire take = access && !pready_out;
  wire commit = access && pready_out;
  wire wr_commit = commit && pwrite_in;
  wire [2:0] sel = port_sel(paddr_in);
  wire hit_latch = port_ok(paddr_in, LATCH_BASE);
  wire hit_pin = port_ok(paddr_in, PIN_BASE);
  wire hit_ana = (paddr_in == ANA_MASK_OFS);
  wire hit_cfg = (paddr_in == SYS_CFG_OFS);
  wire hit_conv = (paddr_in == CONV_CTRL0_OFS);
  wire register_map_select = sys_cfg_r[REGISTER_MAP_SELECT_BIT];
  wire ana_ok = hit_ana && register_map_select;
  wire wr_latch = wr_commit && hit_latch;
  wire wr_ana = wr_commit && ana_ok;
  wire wr_cfg = wr_commit && hit_cfg;
  wire wr_conv = wr_commit && hit_conv;

  // flat views of latches and synchronised pins
  wire [NUM_PINS-1:0] latch_flat = {latch_r[5][5:0], latch_r[4], latch_r[3],
                                    latch_r[2], latch_r[1], latch_r[0]};
  wire [7:0] sel_mask = (sel == LAST_PORT) ? P5_MASK : 8'hff;
  wire [47:0] pin_pad = {2'b00, pin_sync};
  wire [7:0] pin_byte = pin_pad[{sel, 3'b000} +: 8];

  // read mux; unmapped, or mask hidden by the map select, answers with an error
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (hit_latch) begin
      rdata_nxt[7:0] = latch_r[sel] & sel_mask;
    end else if (hit_pin) begin
      rdata_nxt[7:0] = pin_byte & sel_mask;
    end else if (ana_ok) begin
      rdata_nxt[7:0] = ana_mask_r;
    end else if (hit_cfg) begin
      rdata_nxt[2:0] = sys_cfg_r;
    end else if (hit_conv) begin
      // reserved bits are not held; zero is one legal undefined value
      rdata_nxt[7:0] = conv_ctrl_r;
    end else begin
      err_nxt = 1'b1;
    end
  end

  // APB answer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= take;
      if (take) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_nxt;
        pslverr_out <= err_nxt;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // port latches; the P0/P2 latches keep their value while the bus borrows the pins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        latch_r[i] <= LATCH_RST;
      end
    end else if (wr_latch) begin
      latch_r[sel] <= pwdata_in[7:0] & sel_mask;
    end
  end

  // control registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ana_mask_r <= ANA_MASK_RST;
      conv_ctrl_r <= CONV_CTRL0_RST;
      sys_cfg_r <= SYS_CFG_RST;
    end else begin
      if (wr_ana) begin
        ana_mask_r <= pwdata_in[7:0];
      end
      if (wr_conv) begin
        conv_ctrl_r <= pwdata_in[7:0] & CONV_CTRL0_USED;
      end
      if (wr_cfg) begin
        sys_cfg_r <= pwdata_in[2:0];
      end
    end
  end

  // alternate output values; an idle alternate sits at one and leaves the latch in charge
  wire clk_en = conv_ctrl_r[CLK_EN_BIT];
  wire lcd_en = sys_cfg_r[LCD_EN_BIT];
  // sysclk comes from the same state sequence as the core's read/write
  // strobes, so the pulse lines up with their last state 3
  wire clk_alt = clk_en ? sysclk : 1'b1;
  wire col31 = lcd_en ? lcd_col_in[15] : 1'b1;
  wire col30 = lcd_en ? lcd_col_in[14] : 1'b1;
  wire [13:0] cols_p45 = lcd_en ? lcd_col_in[13:0] : 14'h3fff;

  logic [NUM_PINS-1:0] alt;
  always_comb begin
    alt = '1;
    alt[SYSTEM_CLOCK_PIN_PIN] = clk_alt;
    alt[TXD_PIN] = txd_in;
    alt[WR_PIN] = wr_strobe_n_in;
    alt[RD_PIN] = rd_strobe_n_in;
    alt[COL31_PIN] = col31;
    alt[COL30_PIN] = col30;
    alt[NUM_PINS-1:P4_BASE] = cols_p45;
  end

  // latch zero forces the pin low whatever the alternate says
  wire [NUM_PINS-1:0] drive_val = latch_flat & alt;

  // pad drivers
  wire xmem_p0 = xmem_in.active && xmem_in.p0_drive;
  wire xmem_p2 = xmem_in.active && xmem_in.wide;
  always_comb begin
    // quasi pins: oe only while pulling low, weak pull-up outside holds ones
    pin_out_nxt = drive_val;
    pin_oe_nxt = ~drive_val;
    pullup_nxt = 8'h00;
    // analog pins: every driver off
    for (int i = 0; i < 8; i++) begin
      if (!ana_mask_r[i]) begin
        pin_oe_nxt[P1_BASE + i] = 1'b0;
      end
    end
    // port 0: open drain in I/O use, latch one floats the pin
    pin_oe_nxt[7:0] = ~latch_flat[7:0];
    pin_out_nxt[7:0] = 8'h00;
    if (xmem_p0) begin
      // address low byte then data, as sequenced by the core
      pin_out_nxt[7:0] = xmem_in.p0_data;
      pin_oe_nxt[7:0] = 8'hff;
      pullup_nxt = xmem_in.p0_data;
    end
    if (xmem_p2) begin
      pin_out_nxt[P3_BASE-1:P2_BASE] = xmem_in.addr_hi;
      pin_oe_nxt[P3_BASE-1:P2_BASE] = 8'hff;
    end
  end

  // every pad and core output leaves from a flop
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out <= '1;
      pin_oe_out <= '0;
      p0_pullup_en_out <= 8'h00;
      pin_level_out <= '0;
      analog_sel_out <= 8'h00;
      mstate_out <= ST_S1;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe_out <= pin_oe_nxt;
      p0_pullup_en_out <= pullup_nxt;
      pin_level_out <= pin_sync;
      analog_sel_out <= ~ana_mask_r;
      mstate_out <= state;
    end
  end

endmodule : qbp_ports

// ==== verification/qbp_ports_chk.sv ====
// checker of the port block: bus handshake, sequencer and pin drivers
// assumes it is bound to qbp_ports and sees only its ports
`timescale 1ns/1ps
module qbp_ports_chk
  import qbp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // watched ports
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire qbp_xmem_t xmem_in,
  input wire logic [7:0] analog_sel_out,
  input wire qbp_state_t mstate_out,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_out,
  input wire logic [7:0] p0_pullup_en_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire xdrv = xmem_in.active & xmem_in.p0_drive;
  wire xwide = xmem_in.active & xmem_in.wide;
  wire [7:0] xlo = xmem_in.p0_data;
  wire [7:0] xhi = xmem_in.addr_hi;
  sequence acc_start;
    psel_in && $rose(penable_in);
  endsequence
  sequence one_ready;
    pready_out ##1 !pready_out;
  endsequence
  ready_time_a: assert property (acc_start |=> one_ready)
    else $error("ready not one cycle after access");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  state_hot_a: assert property ($onehot(mstate_out))
    else $error("machine state not one-hot");
  state_step_a: assert property (!$stable(mstate_out) |->
    mstate_out[0] == $past(mstate_out[5]) && mstate_out[5:1] == $past(mstate_out[4:0]))
    else $error("machine state skipped");
  analog_off_a: assert property (
    (analog_sel_out & $past(analog_sel_out) & pin_oe_out[15:8]) == 8'h00)
    else $error("analog pin driven");
  pull_only_a: assert property (p0_pullup_en_out != 8'h00 |-> $past(xdrv))
    else $error("port 0 pull-up outside bus cycle");
  p0_mux_a: assert property ($past(xdrv) |->
    pin_out[7:0] == $past(xlo) && pin_oe_out[7:0] == 8'hff)
    else $error("port 0 not carrying bus byte");
  p2_addr_a: assert property ($past(xwide) |->
    pin_out[23:16] == $past(xhi) && pin_oe_out[23:16] == 8'hff)
    else $error("port 2 not carrying high address");
  quasi_low_a: assert property ((pin_out & pin_oe_out & 46'h3fffff00ff00) == 46'h0)
    else $error("quasi pin driven high");
endmodule : qbp_ports_chk

bind qbp_ports qbp_ports_chk chk (.clk_in, .nrst_in, .psel_in, .penable_in, .pready_out,
  .pslverr_out, .xmem_in, .analog_sel_out, .mstate_out, .pin_out, .pin_oe_out,
  .p0_pullup_en_out);

// ==== verification/qbp_pad_model.sv ====
// pad model: pull-ups, floating port 0 and outside drivers
// assumes pad controls are registers of clk_in
`timescale 1ns/1ps
module qbp_pad_model
  import qbp_pkg::*;
(
  // clock
  input wire logic clk_in,
  // block side and outside sources
  input wire logic [NUM_PINS-1:0] drv_val_in,
  input wire logic [NUM_PINS-1:0] drv_en_in,
  input wire logic [NUM_PINS-1:0] ext_en_in,
  input wire logic [NUM_PINS-1:0] ext_val_in,
  // wire levels
  output logic [NUM_PINS-1:0] lvl_out
);
  // undriven port 0 changes every cycle so no stale value reads as valid
  logic [7:0] float_r = 8'h5a;
  always_ff @(posedge clk_in) float_r <= ~float_r;
  // ports 1-5 weak pull-up, port 0 floats
  assign lvl_out = (drv_en_in & drv_val_in) | (~drv_en_in & ext_en_in & ext_val_in)
    | (~drv_en_in & ~ext_en_in & {{38{1'b1}}, float_r});
endmodule : qbp_pad_model

// ==== verification/qbp_ports_test.sv ====
// self-checking bench of the port block with a pad model
// assumes the package offsets and the bus timing of the block
`timescale 1ns/1ps
module qbp_ports_test
  import qbp_pkg::*;
();
  logic clk_in = 0, nrst_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, rd, seed = 32'h653d;
  logic rd_strobe_n_in = 1, wr_strobe_n_in = 1, txd_in = 1, er;
  logic [15:0] lcd_col_in = 16'h0;
  qbp_xmem_t xmem_in = '0;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out;
  wire [45:0] pin_level_out, pin_out, pin_oe_out, pin_in;
  wire [7:0] analog_sel_out, p0_pullup_en_out;
  qbp_state_t mstate_out;
  logic [45:0] ext_en = '0, ext_val = '0;
  logic [7:0] lat [6];
  int bad_count = 0, tests_run = 0, cyc = 0, hi, per;
  qbp_ports dut (.clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .xmem_in, .rd_strobe_n_in, .wr_strobe_n_in,
    .txd_in, .lcd_col_in, .pin_level_out, .analog_sel_out, .mstate_out, .pin_in, .pin_out,
    .pin_oe_out, .p0_pullup_en_out);
  qbp_pad_model pads (.clk_in, .drv_val_in(pin_out), .drv_en_in(pin_oe_out),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .lvl_out(pin_in));
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  function logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function logic [7:0] exp_lat(int p, logic [7:0] v);
    return p == 5 ? v & P5_MASK : v;
  endfunction : exp_lat
  function logic [31:0] exp_pin(int p);
    logic [47:0] v;
    v = {2'b00, ext_en & ext_val};
    return 32'(v[8*p +: 8]);
  endfunction : exp_pin
  task give_verdict();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    // wait ends when pready rises; the cycle ceiling ends the run if it never does
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask : apb
  task rchk(input logic [7:0] a, input logic [31:0] e, input logic ee, input string nm);
    apb(1'b0, a, 32'h0);
    chk(rd, e, nm);
    chk(er, ee, nm);
  endtask : rchk
  // one clock-out period from rise to rise, with the time it stays high
  task meas();
    while (pin_in[SYSTEM_CLOCK_PIN_PIN] !== 1'b0) @(posedge clk_in);
    while (pin_in[SYSTEM_CLOCK_PIN_PIN] !== 1'b1) @(posedge clk_in);
    hi = 0;
    per = 0;
    do begin
      if (pin_in[SYSTEM_CLOCK_PIN_PIN] === 1'b1) begin
        hi++;
        // pin and state output leave their flops on the same edge
        chk(mstate_out, ST_S3, "state under high");
      end
      @(posedge clk_in);
      per++;
    end while (!(pin_in[SYSTEM_CLOCK_PIN_PIN] === 1'b1 && hi < per));
  endtask : meas
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    nrst_in <= 1;
    for (int p = 0; p < 6; p++) rchk(8'(LATCH_BASE + 4*p), exp_lat(p, 8'hff), 0, "rst");
    chk(pin_oe_out, 46'h0, "oe after reset");
    rchk(ANA_MASK_OFS, 0, 1, "mask locked");
    rchk(8'h80, 0, 1, "unmapped");
    for (int k = 0; k < 8; k++) begin
      for (int p = 0; p < 6; p++) begin
        seed = lfsr(seed);
        lat[p] = exp_lat(p, seed[7:0]);
        apb(1'b1, 8'(LATCH_BASE + 4*p), seed);
      end
      seed = lfsr(seed);
      ext_val <= {seed[13:0], seed};
      ext_en <= {lat[5][5:0], lat[4], lat[3], lat[2], lat[1], lat[0]};
      repeat (4) @(posedge clk_in);
      for (int p = 0; p < 6; p++) begin
        rchk(8'(LATCH_BASE + 4*p), lat[p], 0, "read latch");
        rchk(8'(PIN_BASE + 4*p), exp_pin(p), 0, "read pin");
      end
      chk(pin_level_out, ext_en & ext_val, "pin level");
    end
    ext_en <= '0;
    for (int p = 0; p < 6; p++) apb(1'b1, 8'(LATCH_BASE + 4*p), 32'hff);
    apb(1'b1, SYS_CFG_OFS, 32'h1);
    seed = lfsr(seed);
    apb(1'b1, ANA_MASK_OFS, seed);
    // latch zero would pull every digital pin low; analog ones must stay undriven
    apb(1'b1, 8'(LATCH_BASE + 4), 32'h00);
    rchk(ANA_MASK_OFS, seed[7:0], 0, "mask");
    chk(analog_sel_out, 8'(~seed[7:0]), "analog sel");
    chk(pin_oe_out[15:8], seed[7:0], "analog drivers off");
    apb(1'b1, ANA_MASK_OFS, 32'hff);
    apb(1'b1, 8'(LATCH_BASE + 4), 32'hff);
    apb(1'b1, CONV_CTRL0_OFS, 32'hff);
    apb(1'b0, CONV_CTRL0_OFS, 32'h0);
    chk(rd[CLK_EN_BIT], 1'b1, "clock enable");
    meas();
    chk(hi, 2, "clock high");
    chk(per, 12, "clock period");
    apb(1'b1, SYS_CFG_OFS, 32'h5);
    repeat (400) @(posedge clk_in);
    meas();
    chk(hi, 2*32, "slow high");
    chk(per, 12*32, "slow period");
    apb(1'b1, SYS_CFG_OFS, 32'h0);
    apb(1'b1, 8'(LATCH_BASE + 4), 32'hbf);
    // pin follows the latch one edge after the write lands
    @(posedge clk_in);
    repeat (24) begin
      @(posedge clk_in);
      chk(pin_in[SYSTEM_CLOCK_PIN_PIN], 1'b0, "gated clock");
    end
    apb(1'b1, 8'(LATCH_BASE + 4), 32'hff);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      xmem_in <= '{1'b1, seed[16], 1'b1, seed[15:8], seed[7:0]};
      repeat (3) @(posedge clk_in);
      chk(pin_out[23:16], seed[16] ? seed[15:8] : 8'hff, "p2 addr");
      chk(pin_out[7:0], seed[7:0], "p0 data");
      chk(p0_pullup_en_out, seed[7:0], "p0 pull-up");
    end
    xmem_in <= '0;
    repeat (3) @(posedge clk_in);
    chk(p0_pullup_en_out, 8'h00, "pull-up idle");
    apb(1'b1, SYS_CFG_OFS, 32'h2);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      {rd_strobe_n_in, wr_strobe_n_in, txd_in} <= seed[18:16];
      lcd_col_in <= seed[15:0];
      repeat (3) @(posedge clk_in);
      chk({pin_in[RD_PIN], pin_in[WR_PIN], pin_in[TXD_PIN]}, seed[18:16], "p3 alt");
      chk({pin_in[COL31_PIN], pin_in[COL30_PIN], pin_in[45:32]}, seed[15:0], "lcd");
    end
    give_verdict();
  end
endmodule : qbp_ports_test
